// *** logic/isrc_defines.svh ***
// Offsets, field positions and reset values of the interrupt source block
`ifndef ISRC_DEFINES_SVH
`define ISRC_DEFINES_SVH
`define ISRC_OFS_PSC 8'h00
`define ISRC_OFS_TB0 8'h04
`define ISRC_OFS_TB1 8'h08
`define ISRC_OFS_EN 8'h0C
`define ISRC_OFS_FLAG 8'h10
`define ISRC_OFS_SRC 8'h14
`define ISRC_PSC_ON_BIT 2
`define ISRC_TB_RUN_BIT 7
`define ISRC_GIE_BIT 8
`define ISRC_SRC_EN_LSB 8
`define ISRC_PSC_RST 8'h00
`define ISRC_TB_RST 8'h00
`define ISRC_V_LC0 0
`define ISRC_V_LC1 1
`define ISRC_V_GRP0 2
`define ISRC_V_TB0 3
`define ISRC_V_TB1 4
`define ISRC_V_SER 5
`define ISRC_V_GRP1 6
`define ISRC_V_LOW 7
`define ISRC_GRP0_MASK 6'h07
`define ISRC_GRP1_MASK 6'h38
`endif

// *** logic/isrc_pkg.sv ***
// Types shared by the interrupt source block
package isrc_pkg;
  // Same-clock event pulses from the source peripherals
  typedef struct packed {
    logic conv_done;
    logic eeprom_done;
    logic ptm_req;
    logic stm_req;
    logic [1:0][5:0] uart_evt;
    logic [2:0] serial_evt;
  } isrc_evt_t;

  // Whole state of the block
  typedef struct packed {
    logic [1:0] cmp_s1;
    logic [1:0] cmp_s2;
    logic [1:0] cmp_s3;
    logic [1:0] clk_s1;
    logic [1:0] clk_s2;
    logic [1:0] clk_s3;
    logic lvd_s1;
    logic lvd_s2;
    logic lvd_s3;
    logic [1:0] div4;
    logic [1:0][14:0] tb_cnt;
    logic [7:0] psc;
    logic [1:0][7:0] tbc;
    logic [8:0] en;
    logic [7:0] flags;
    logic [5:0] src_flag;
    logic [5:0] src_en;
    logic irq_req;
    logic [2:0] vec;
    logic wake;
    logic [31:0] rdata;
  } isrc_state_t;
endpackage

// *** logic/isrc_top.sv ***
// Interrupt request logic with prescaler and two time bases, APB register slave
`timescale 1ns/1ps
`include "isrc_defines.svh"
module isrc_top (
  input wire logic mclk, // System clock, 40 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [1:0] line_cmp_out, // Comparator outputs, asynchronous
  input wire logic low_supply_detector, // Low supply report, asynchronous
  input wire logic sub_clk, // Subsystem clock, sampled
  input wire logic lxt_clk, // Low-speed crystal clock, sampled
  input wire isrc_pkg::isrc_evt_t evt, // Peripheral event pulses
  input wire logic stack_full, // Core stack is full
  input wire logic irq_ack, // Core takes the presented vector
  input wire logic return_from_irq, // Core executes interrupt return
  output logic irq_req, // Vector call request
  output logic [2:0] irq_vec, // Vector index, lower wins
  output logic wake // Wake pulse on any flag rise
);

  isrc_pkg::isrc_state_t r;
  isrc_pkg::isrc_state_t n;
  logic psc_tick;
  logic [1:0] tb_ovf;
  logic [7:0] hw_set;
  logic [5:0] src_set;
  logic [7:0] req;
  logic wr;
  logic rd_setup;
  logic hit;

  // Overflow mask for a period code: 2^(8+code)-1
  function automatic logic [14:0] tb_mask(input logic [2:0] sel);
    tb_mask = 15'h7FFF >> (3'h7 - sel);
  endfunction

  // Lowest set index wins
  function automatic logic [2:0] prio(input logic [7:0] v);
    prio = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        prio = 3'(i);
      end
    end
  endfunction

  // Address decode; every access completes with no wait state
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign hit = (paddr == `ISRC_OFS_PSC) || (paddr == `ISRC_OFS_TB0) || (paddr == `ISRC_OFS_TB1) ||
               (paddr == `ISRC_OFS_EN) || (paddr == `ISRC_OFS_FLAG) || (paddr == `ISRC_OFS_SRC);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = r.rdata;
  assign irq_req = r.irq_req;
  assign irq_vec = r.vec;
  assign wake = r.wake;

  // Prescaler tick: one enable pulse per prescaler clock period
  always_comb begin
    psc_tick = 1'b0;
    if (r.psc[`ISRC_PSC_ON_BIT]) begin
      case (r.psc[1:0])
        2'h0: psc_tick = 1'b1;
        2'h1: psc_tick = (r.div4 == 2'h3);
        2'h2: psc_tick = r.clk_s2[0] && !r.clk_s3[0];
        2'h3: psc_tick = r.clk_s2[1] && !r.clk_s3[1];
        default: psc_tick = 1'b0;
      endcase
    end
  end

  // Time base overflow when the low 8+code counter bits are all ones
  always_comb begin
    for (int t = 0; t < 2; t++) begin
      tb_ovf[t] = r.tbc[t][`ISRC_TB_RUN_BIT] && psc_tick &&
                  ((r.tb_cnt[t] & tb_mask(r.tbc[t][2:0])) == tb_mask(r.tbc[t][2:0]));
    end
  end

  // Hardware set sources for the vector flags and group members
  always_comb begin
    src_set = {evt.stm_req, |evt.uart_evt[1], |evt.uart_evt[0], evt.ptm_req, evt.eeprom_done,
               evt.conv_done};
    hw_set = 8'h00;
    hw_set[`ISRC_V_LC0] = r.cmp_s2[0] ^ r.cmp_s3[0];
    hw_set[`ISRC_V_LC1] = r.cmp_s2[1] ^ r.cmp_s3[1];
    hw_set[`ISRC_V_TB0] = tb_ovf[0];
    hw_set[`ISRC_V_TB1] = tb_ovf[1];
    hw_set[`ISRC_V_SER] = |evt.serial_evt;
    hw_set[`ISRC_V_LOW] = r.lvd_s2 && !r.lvd_s3;
  end

  // Next state
  always_comb begin
    n = r;
    // Asynchronous pins pass two flops; the third only feeds edge detection
    n.cmp_s1 = line_cmp_out;
    n.cmp_s2 = r.cmp_s1;
    n.cmp_s3 = r.cmp_s2;
    n.clk_s1 = {lxt_clk, sub_clk};
    n.clk_s2 = r.clk_s1;
    n.clk_s3 = r.clk_s2;
    n.lvd_s1 = low_supply_detector;
    n.lvd_s2 = r.lvd_s1;
    n.lvd_s3 = r.lvd_s2;
    n.div4 = r.div4 + 2'h1;
    // Counters restart from zero while stopped so the first period is whole
    for (int t = 0; t < 2; t++) begin
      if (!r.tbc[t][`ISRC_TB_RUN_BIT]) begin
        n.tb_cnt[t] = 15'h0000;
      end else if (psc_tick) begin
        n.tb_cnt[t] = r.tb_cnt[t] + 15'h0001;
      end
    end
    // Register writes; software may both set and clear flags
    if (wr) begin
      case (paddr)
        `ISRC_OFS_PSC: n.psc = {5'h00, pwdata[2:0]};
        `ISRC_OFS_TB0: n.tbc[0] = {pwdata[7], 4'h0, pwdata[2:0]};
        `ISRC_OFS_TB1: n.tbc[1] = {pwdata[7], 4'h0, pwdata[2:0]};
        `ISRC_OFS_EN: n.en = pwdata[8:0];
        `ISRC_OFS_FLAG: n.flags = pwdata[7:0];
        `ISRC_OFS_SRC: begin
          n.src_flag = pwdata[5:0];
          n.src_en = pwdata[13:8];
        end
        default: n.en = r.en;
      endcase
    end
    // Service clears only the presented vector flag, never a group member
    if (irq_ack && r.irq_req) begin
      n.flags[r.vec] = 1'b0;
      n.en[`ISRC_GIE_BIT] = 1'b0;
    end
    if (return_from_irq) begin
      n.en[`ISRC_GIE_BIT] = 1'b1;
    end
    // Hardware sets win over any clear in the same cycle; flags otherwise hold
    n.src_flag = n.src_flag | src_set;
    n.flags = n.flags | hw_set;
    if (|(src_set & ~r.src_flag & `ISRC_GRP0_MASK)) begin
      n.flags[`ISRC_V_GRP0] = 1'b1;
    end
    if (|(src_set & ~r.src_flag & `ISRC_GRP1_MASK)) begin
      n.flags[`ISRC_V_GRP1] = 1'b1;
    end
    // Request built from next state so the vector never lags the flags
    req = n.flags & n.en[7:0];
    req[`ISRC_V_GRP0] = req[`ISRC_V_GRP0] && |(n.src_flag & n.src_en & `ISRC_GRP0_MASK);
    req[`ISRC_V_GRP1] = req[`ISRC_V_GRP1] && |(n.src_flag & n.src_en & `ISRC_GRP1_MASK);
    n.irq_req = (|req) && n.en[`ISRC_GIE_BIT] && !stack_full;
    n.vec = prio(req);
    n.wake = |(n.flags & ~r.flags);
    // Read data latched in the setup phase, ready for the access phase
    if (rd_setup) begin
      case (paddr)
        `ISRC_OFS_PSC: n.rdata = {24'h000000, r.psc};
        `ISRC_OFS_TB0: n.rdata = {24'h000000, r.tbc[0]};
        `ISRC_OFS_TB1: n.rdata = {24'h000000, r.tbc[1]};
        `ISRC_OFS_EN: n.rdata = {23'h000000, r.en};
        `ISRC_OFS_FLAG: n.rdata = {24'h000000, r.flags};
        `ISRC_OFS_SRC: n.rdata = {18'h00000, r.src_en, 2'h0, r.src_flag};
        default: n.rdata = 32'h00000000;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.psc <= `ISRC_PSC_RST;
      r.tbc[0] <= `ISRC_TB_RST;
      r.tbc[1] <= `ISRC_TB_RST;
    end else begin
      r <= n;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  cmp_toggle_set_a: assert property ((r.cmp_s2[0] != r.cmp_s3[0]) |=> r.flags[0])
    else $error("comparator toggle did not set its flag");
  ack_clears_gie_a: assert property ((irq_ack && r.irq_req && !return_from_irq && !(wr && paddr == `ISRC_OFS_EN))
    |=> !r.en[`ISRC_GIE_BIT])
    else $error("service did not clear global enable");
  req_needs_gie_a: assert property (r.irq_req |-> r.en[`ISRC_GIE_BIT] && r.en[r.vec])
    else $error("request without enables");
  stack_blocks_a: assert property (stack_full |=> !r.irq_req)
    else $error("request while stack full");
  return_from_irq_sets_gie_a: assert property (return_from_irq |=> r.en[`ISRC_GIE_BIT])
    else $error("return did not set global enable");
  flag_rise_wake_a: assert property ((|(r.flags & ~$past(r.flags))) |-> r.wake)
    else $error("flag rise without wake");
  group_src_keep_a: assert property ((irq_ack && !(wr && paddr == `ISRC_OFS_SRC))
    |=> (r.src_flag & $past(r.src_flag)) == $past(r.src_flag))
    else $error("service cleared a source flag");
  tick_ovf_flag_a: assert property (tb_ovf[1] |=> r.flags[`ISRC_V_TB1])
    else $error("time base overflow lost");
  psc_off_stop_a: assert property (!r.psc[`ISRC_PSC_ON_BIT] |-> !psc_tick && !tb_ovf[0])
    else $error("prescaler ticked while off");
  tick_flag_hold_a: assert property ((r.flags[`ISRC_V_TB0] && !irq_ack && !(wr && paddr == `ISRC_OFS_FLAG))
    |=> r.flags[`ISRC_V_TB0])
    else $error("time base flag dropped");

  // Second comparator toggles set its own flag
  cmp1_toggle_set_a: assert property ((r.cmp_s2[1] != r.cmp_s3[1]) |=> r.flags[`ISRC_V_LC1])
    else $error("comparator one toggle did not set its flag");

  // Only a rise of the synchronised detector output counts as a report
  low_rise_set_a: assert property ((r.lvd_s2 && !r.lvd_s3) |=> r.flags[`ISRC_V_LOW])
    else $error("low supply report lost");

  // Any of the three serial events raises the serial flag
  serial_evt_set_a: assert property ((|evt.serial_evt) |=> r.flags[`ISRC_V_SER])
    else $error("serial event lost");

  // First time base overflow is not dropped either
  tick0_ovf_flag_a: assert property (tb_ovf[0] |=> r.flags[`ISRC_V_TB0])
    else $error("time base zero overflow lost");

  // Conversion done lands in its source flag
  conv_src_set_a: assert property (evt.conv_done |=> r.src_flag[0])
    else $error("conversion done lost");

  // EEPROM write end lands in its source flag
  eeprom_src_set_a: assert property (evt.eeprom_done |=> r.src_flag[1])
    else $error("eeprom write end lost");

  // Any condition of UART zero lands in that UART's source flag
  uart_src_set_a: assert property ((|evt.uart_evt[0]) |=> r.src_flag[3])
    else $error("uart request lost");

  // Timer members of the groups land in their source flags
  ptm_src_set_a: assert property (evt.ptm_req |=> r.src_flag[2])
    else $error("periodic timer request lost");
  stm_src_set_a: assert property (evt.stm_req |=> r.src_flag[5])
    else $error("standard timer request lost");

  // A newly set member raises its group flag
  group0_set_a: assert property ((|(src_set & ~r.src_flag & `ISRC_GRP0_MASK)) |=> r.flags[`ISRC_V_GRP0])
    else $error("group zero flag not set");
  group1_set_a: assert property ((|(src_set & ~r.src_flag & `ISRC_GRP1_MASK)) |=> r.flags[`ISRC_V_GRP1])
    else $error("group one flag not set");

  // Nothing outside the member list raises a group flag
  group_no_stray_a: assert property ((src_set == 6'h00 && !r.flags[`ISRC_V_GRP0] && !(wr && paddr == `ISRC_OFS_FLAG))
    |=> !r.flags[`ISRC_V_GRP0])
    else $error("group flag set by a non member");

  // Service of the comparator vector clears its flag unless a new toggle lands
  lc_ack_clear_a: assert property ((irq_ack && r.irq_req && r.vec == 3'h0 && !hw_set[`ISRC_V_LC0] &&
    !(wr && paddr == `ISRC_OFS_FLAG)) |=> !r.flags[`ISRC_V_LC0])
    else $error("comparator flag not cleared on service");

  // Service of a time base vector clears its flag unless it overflows again
  tb_ack_clear_a: assert property ((irq_ack && r.irq_req && r.vec == 3'h3 && !tb_ovf[0] &&
    !(wr && paddr == `ISRC_OFS_FLAG)) |=> !r.flags[`ISRC_V_TB0])
    else $error("time base flag not cleared on service");

  // Service of the serial vector clears its flag
  ser_ack_clear_a: assert property ((irq_ack && r.irq_req && r.vec == 3'h5 && !(|evt.serial_evt) &&
    !(wr && paddr == `ISRC_OFS_FLAG)) |=> !r.flags[`ISRC_V_SER])
    else $error("serial flag not cleared on service");

  // Service of the low supply vector clears its flag
  low_ack_clear_a: assert property ((irq_ack && r.irq_req && r.vec == 3'h7 && !hw_set[`ISRC_V_LOW] &&
    !(wr && paddr == `ISRC_OFS_FLAG)) |=> !r.flags[`ISRC_V_LOW])
    else $error("low supply flag not cleared on service");

  // Service of a group vector clears the group flag itself
  grp_ack_clear_a: assert property ((irq_ack && r.irq_req && r.vec == 3'h2 &&
    !(|(src_set & ~r.src_flag & `ISRC_GRP0_MASK)) && !(wr && paddr == `ISRC_OFS_FLAG))
    |=> !r.flags[`ISRC_V_GRP0])
    else $error("group flag not cleared on service");

  // A group vector needs a member with flag and enable both set
  group_gate_a: assert property ((r.irq_req && r.vec == 3'h2) |-> |(r.src_flag & r.src_en & `ISRC_GRP0_MASK))
    else $error("group call without an enabled member");

  // Lower index wins: vector zero pending and enabled hides every other
  prio_lowest_a: assert property ((r.irq_req && r.vec != 3'h0) |-> !(r.flags[0] && r.en[0]))
    else $error("higher vector served first");

  // Wake only follows a real flag rise
  wake_needs_rise_a: assert property (r.wake |-> |(r.flags & ~$past(r.flags)))
    else $error("wake without flag rise");

  // System clock source ticks every cycle while enabled
  psc_sys_tick_a: assert property ((r.psc[`ISRC_PSC_ON_BIT] && r.psc[1:0] == 2'h0) |-> psc_tick)
    else $error("system clock source did not tick");

  // A stopped time base restarts from zero
  tb_stop_clear_a: assert property (!r.tbc[0][`ISRC_TB_RUN_BIT] |=> r.tb_cnt[0] == 15'h0000)
    else $error("stopped time base kept counting");

  // A running time base only moves on a prescaler tick
  tb_count_hold_a: assert property ((r.tbc[0][`ISRC_TB_RUN_BIT] && !psc_tick)
    |=> r.tb_cnt[0] == $past(r.tb_cnt[0]))
    else $error("time base moved without a tick");

  // Source flags hold until software writes them
  src_flag_hold_a: assert property ((r.src_flag[0] && !(wr && paddr == `ISRC_OFS_SRC)) |=> r.src_flag[0])
    else $error("source flag dropped");

  // Low supply flag holds while disabled and unserviced
  low_flag_hold_a: assert property ((r.flags[`ISRC_V_LOW] && !irq_ack && !(wr && paddr == `ISRC_OFS_FLAG))
    |=> r.flags[`ISRC_V_LOW])
    else $error("low supply flag dropped");

  // Comparator vector needs its own enable and the global one
  lc_gate_a: assert property ((r.irq_req && r.vec == 3'h0) |-> r.en[0] && r.en[`ISRC_GIE_BIT])
    else $error("comparator call without enables");

  // Serial vector needs its own enable and the global one
  ser_gate_a: assert property ((r.irq_req && r.vec == 3'h5) |-> r.en[5] && r.en[`ISRC_GIE_BIT])
    else $error("serial call without enables");

  // Low supply vector needs its own enable and the global one
  low_gate_a: assert property ((r.irq_req && r.vec == 3'h7) |-> r.en[7] && r.en[`ISRC_GIE_BIT])
    else $error("low supply call without enables");

endmodule

// *** testbench/isrc_core_model.sv ***
// Core model: takes a standing vector call after a programmable wait
`timescale 1ns/1ps
module isrc_core_model (
  input wire logic mclk, // System clock
  input wire logic arst_n, // Reset, active low
  input wire logic irq_req, // Vector call request
  input wire logic [2:0] irq_vec, // Presented vector
  input wire logic ack_en, // Core accepts calls
  input wire logic [3:0] dly, // Wait cycles before taking
  output logic irq_ack, // Take pulse
  output logic [2:0] last_vec, // Vector taken last
  output logic [7:0] n_ack // Calls taken
);
  logic [3:0] cnt;
  // One pulse per call; no second take while the first lands
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      irq_ack <= 1'b0;
      last_vec <= 3'h0;
      n_ack <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      cnt <= 4'h0;
      if (irq_req && ack_en && !irq_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt == dly) begin
          irq_ack <= 1'b1;
          last_vec <= irq_vec;
          n_ack <= n_ack + 8'h01;
          cnt <= 4'h0;
        end
      end
    end
  end
endmodule

// *** testbench/isrc_top_tb.sv ***
// Self-checking bench for the interrupt source block
`timescale 1ns/1ps
module isrc_top_tb;
  logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, n_ack, div = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, en_v;
  logic pready, pslverr, err, sub_clk = 1'b0, lxt_clk = 1'b0, low_supply_detector = 1'b0;
  logic stack_full = 1'b0, irq_ack, return_from_irq = 1'b0, irq_req, wake, ack_en = 1'b0;
  logic [1:0] line_cmp_out = 2'h0;
  logic [2:0] irq_vec, last_vec;
  logic [3:0] dly = 4'h0;
  isrc_pkg::isrc_evt_t evt = '0;
  int fails = 0, n_tests = 0, n_wake = 0, cyc;
  always #12.5 mclk = ~mclk;
  // Slow clocks of 8 and 16 system cycles; wake pulses counted
  always @(posedge mclk) begin
    div <= div + 8'h01;
    sub_clk <= div[2];
    lxt_clk <= div[3];
    if (wake === 1'b1) n_wake <= n_wake + 1;
  end
  isrc_top i_isrc_top (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_cmp_out(line_cmp_out), .low_supply_detector(low_supply_detector), .sub_clk(sub_clk),
    .lxt_clk(lxt_clk), .evt(evt), .stack_full(stack_full), .irq_ack(irq_ack),
    .return_from_irq(return_from_irq), .irq_req(irq_req), .irq_vec(irq_vec), .wake(wake));
  isrc_core_model i_isrc_core_model (.mclk(mclk), .arst_n(arst_n), .irq_req(irq_req), .irq_vec(irq_vec),
    .ack_en(ack_en), .dly(dly), .irq_ack(irq_ack), .last_vec(last_vec), .n_ack(n_ack));
  task chk(input logic ok, input string m);
    n_tests++;
    if (!ok) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task wrap_up;
    $display("Checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request held until pready is seen high at an edge
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (cyc = 0; cyc < 50; cyc++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (cyc == 50) begin
      chk(1'b0, "bus hang");
      wrap_up;
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(q === e && err === 1'b0, "read");
  endtask
  task set_en(input logic [31:0] v);
    en_v = v;
    wr(8'h0C, v);
  endtask
  task wait_irq(input logic [2:0] v);
    for (cyc = 0; cyc < 6000 && irq_req !== 1'b1; cyc++) @(posedge mclk);
    if (cyc == 6000) begin
      chk(1'b0, "no call");
      wrap_up;
    end
    chk(irq_vec === v, "vector");
  endtask
  task serve(input logic [2:0] v);
    logic [7:0] n0;
    n0 = n_ack;
    ack_en <= 1'b1;
    for (cyc = 0; cyc < 40 && n_ack === n0; cyc++) @(posedge mclk);
    ack_en <= 1'b0;
    if (cyc == 40) begin
      chk(1'b0, "not taken");
      wrap_up;
    end
    chk(last_vec === v, "taken");
    repeat (2) @(posedge mclk);
  endtask
  // Event, call, service, flag check, interrupt return
  task fire(input isrc_pkg::isrc_evt_t e, input logic [2:0] v, input logic [31:0] fl);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    wait_irq(v);
    serve(v);
    rd(8'h10, fl);
    rd(8'h0C, en_v & 32'hFF);
    @(posedge mclk);
    return_from_irq <= 1'b1;
    @(posedge mclk);
    return_from_irq <= 1'b0;
    rd(8'h0C, en_v);
  endtask
  task t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 32'hFF);
    rd(8'h00, 32'h7);
    wr(8'h08, 32'hFF);
    rd(8'h08, 32'h87);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    apb(8'h18, 1'b0, 32'h0);
    chk(err === 1'b1 && q === 32'h0, "unmapped");
    $display("regs done");
  endtask
  task t_cmp;
    int w0;
    set_en(32'h101);
    line_cmp_out[0] <= 1'b1;
    fire('0, 3'h0, 32'h0);
    set_en(32'h100);
    w0 = n_wake;
    line_cmp_out[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(irq_req === 1'b0 && n_wake == w0 + 1, "wake");
    rd(8'h10, 32'h1);
    stack_full <= 1'b1;
    set_en(32'h101);
    repeat (6) @(posedge mclk);
    chk(irq_req === 1'b0, "stack full");
    stack_full <= 1'b0;
    fire('0, 3'h0, 32'h0);
    dly <= 4'h6;
    set_en(32'h102);
    line_cmp_out[1] <= 1'b1;
    fire('0, 3'h1, 32'h0);
    set_en(32'h103);
    wr(8'h10, 32'h3);
    wait_irq(3'h0);
    serve(3'h0);
    @(posedge mclk);
    return_from_irq <= 1'b1;
    @(posedge mclk);
    return_from_irq <= 1'b0;
    wait_irq(3'h1);
    serve(3'h1);
    rd(8'h10, 32'h0);
    $display("comparator done");
  endtask
  task t_grp;
    int s;
    isrc_pkg::isrc_evt_t e;
    wr(8'h14, 32'h3E00);
    set_en(32'h144);
    rd(8'h14, 32'h3E00);
    e = '0;
    e.conv_done = 1'b1;
    evt <= e;
    @(posedge mclk);
    evt <= '0;
    repeat (6) @(posedge mclk);
    chk(irq_req === 1'b0, "gated group");
    rd(8'h10, 32'h4);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h3F00);
    for (int k = 0; k < 12; k++) begin
      s = (k < 6) ? k : 3 + k % 2;
      e = '0;
      case (s)
        0: e.conv_done = 1'b1;
        1: e.eeprom_done = 1'b1;
        2: e.ptm_req = 1'b1;
        5: e.stm_req = 1'b1;
        default: e.uart_evt[s - 3][(k < 6) ? 0 : k - 6] = 1'b1;
      endcase
      fire(e, (s < 3) ? 3'h2 : 3'h6, 32'h0);
      rd(8'h14, 32'h3F00 | (32'h1 << s));
      wr(8'h14, 32'h3F00);
    end
    dly <= 4'h0;
    set_en(32'h120);
    for (int j = 0; j < 3; j++) begin
      e = '0;
      e.serial_evt[j] = 1'b1;
      fire(e, 3'h5, 32'h0);
    end
    set_en(32'h180);
    low_supply_detector <= 1'b1;
    fire('0, 3'h7, 32'h0);
    low_supply_detector <= 1'b0;
    $display("groups done");
  endtask
  task t_tb;
    int ex[6] = '{256, 1024, 2048, 4096, 512, 256};
    logic [7:0] a;
    logic [2:0] v;
    for (int i = 0; i < 6; i++) begin
      a = (i == 5) ? 8'h08 : 8'h04;
      v = (i == 5) ? 3'h4 : 3'h3;
      set_en(32'h118);
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h4 | 32'((i < 4) ? i : 0));
      wr(a, 32'h80 | 32'(i == 4));
      wait_irq(v);
      chk(cyc > ex[i] - ex[i] / 32 - 8 && cyc < ex[i] + ex[i] / 32 + 8, "period");
      serve(v);
      wr(a, 32'h0);
      rd(8'h10, 32'h0);
    end
    wr(8'h00, 32'h0);
    set_en(32'h118);
    wr(8'h04, 32'h80);
    repeat (600) @(posedge mclk);
    chk(irq_req === 1'b0, "gated");
    wr(8'h04, 32'h0);
    $display("time base done");
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs;
    t_cmp;
    t_grp;
    t_tb;
    wrap_up;
  end
endmodule
